// ==== hw/lcg_pkg.sv ====
package lcg_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] GLUE_ADDR_DEF = 32'hfff0_0000;
    localparam logic [ADDR_W-1:0] SLAVE_ADDR_DEF = 32'hfff0_0010;
    localparam int SEL_BIT_POS = 0;
    localparam logic SEL_CHAN_ATTN = 1'b0;
    localparam logic SEL_COPROC_INIT = 1'b1;
    localparam logic CHAN_ATTN_RST = 1'b0;
    localparam logic COPROC_INIT_RST = 1'b0;
endpackage : lcg_pkg

// ==== hw/lcg_if.sv ====
`timescale 1ns/1ps
interface lcg_if;
    import lcg_pkg::*;
    logic address_strobe_n;
    logic mem_write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic bus_request;
    logic bus_grant_in;
    logic channel_attention;
    logic coprocessor_init;
    logic slave_access_n;
    logic mem_io_out;
    logic mem_io_oe_n;
    logic data_code_out;
    logic data_code_oe_n;
    logic cop_address_strobe_n;
    logic cop_write;
    logic external_snoop_strobe_n;
    modport glue (
        input address_strobe_n, mem_write, addr, data, bus_request,
        input bus_grant_in, cop_address_strobe_n, cop_write,
        output channel_attention, coprocessor_init, slave_access_n,
        output mem_io_out, mem_io_oe_n, data_code_out, data_code_oe_n,
        output external_snoop_strobe_n
    );
    modport proc (
        output address_strobe_n, mem_write, addr, data, bus_grant_in,
        input bus_request, channel_attention, coprocessor_init,
        input slave_access_n, mem_io_out, mem_io_oe_n, data_code_out,
        input data_code_oe_n, cop_address_strobe_n, cop_write,
        input external_snoop_strobe_n
    );
endinterface : lcg_if

// ==== hw/lcg_glue.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - glue-address write, data bit zero picks signal
// - each signal held until a later glue write
// - assert only while bus grant inactive
// - slave strobe decoded, exactly one clock long
// - coprocessor reads data as slave control then
// - processor keeps coprocessor idle around slave access
// - grant and request drive status lines high
// - snoop strobe pulsed on coprocessor write cycles
// - shared memory should stay uncached
// - channel attention makes coprocessor read control block
module lcg_glue
    import lcg_pkg::*;
#(
    parameter logic [ADDR_W-1:0] GLUE_ADDR = GLUE_ADDR_DEF,
    parameter logic [ADDR_W-1:0] SLAVE_ADDR = SLAVE_ADDR_DEF,
    parameter bit SNOOP_EN = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    lcg_if.glue bus,
    output logic attn_seen,
    output logic init_active
);
    // decoded cycle qualifiers
    logic owner;
    logic cycle_take;
    logic hit_glue;
    logic hit_slave;
    logic sel;
    logic cop_wr_cycle;

    // held control levels
    logic ca_q;
    logic init_q;
    logic next_ca;
    logic next_init;

    // attention pulse
    logic attn_q;
    logic next_attn;

    // slave access strobe
    logic slave_n_q;
    logic next_slave_n;

    // memory/io status line
    logic mio_q;
    logic mio_oe_n_q;
    logic next_mio;
    logic next_mio_oe_n;

    // data/code status line
    logic dc_q;
    logic dc_oe_n_q;
    logic next_dc;
    logic next_dc_oe_n;

    // snoop strobe
    logic snoop_n_q;
    logic next_snoop_n;

    // coprocessor owns the bus
    always_comb begin
        owner = bus.bus_request && bus.bus_grant_in;
    end

    // processor write cycle decode
    always_comb begin
        cycle_take = !bus.address_strobe_n && bus.mem_write && !owner;
        hit_glue = cycle_take && (bus.addr == GLUE_ADDR);
        hit_slave = cycle_take && (bus.addr == SLAVE_ADDR);
        sel = bus.data[SEL_BIT_POS];
    end

    // coprocessor write cycle decode
    always_comb begin
        cop_wr_cycle = owner && !bus.cop_address_strobe_n && bus.cop_write;
    end

    // held control toggles
    always_comb begin
        next_ca = ca_q;
        next_init = init_q;
        if (hit_glue && !bus.bus_grant_in) begin
            if (sel == SEL_CHAN_ATTN) begin
                next_ca = !ca_q;
            end else begin
                next_init = !init_q;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ca_q <= CHAN_ATTN_RST;
            init_q <= COPROC_INIT_RST;
        end else begin
            ca_q <= next_ca;
            init_q <= next_init;
        end
    end

    // one-cycle pulse on attention rise
    always_comb begin
        next_attn = 1'b0;
        if (next_ca && !ca_q) begin
            next_attn = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            attn_q <= 1'b0;
        end else begin
            attn_q <= next_attn;
        end
    end

    // slave strobe, suppressed back to back
    always_comb begin
        next_slave_n = 1'b1;
        if (hit_slave && slave_n_q) begin
            next_slave_n = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            slave_n_q <= 1'b1;
        end else begin
            slave_n_q <= next_slave_n;
        end
    end

    // memory/io driven high while owner
    always_comb begin
        next_mio = 1'b1;
        next_mio_oe_n = 1'b1;
        if (owner) begin
            next_mio_oe_n = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mio_q <= 1'b1;
            mio_oe_n_q <= 1'b1;
        end else begin
            mio_q <= next_mio;
            mio_oe_n_q <= next_mio_oe_n;
        end
    end

    // data/code driven high while owner
    always_comb begin
        next_dc = 1'b1;
        next_dc_oe_n = 1'b1;
        if (owner) begin
            next_dc_oe_n = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dc_q <= 1'b1;
            dc_oe_n_q <= 1'b1;
        end else begin
            dc_q <= next_dc;
            dc_oe_n_q <= next_dc_oe_n;
        end
    end

    // invalidation strobe on coprocessor writes
    always_comb begin
        next_snoop_n = 1'b1;
        if (SNOOP_EN && cop_wr_cycle) begin
            next_snoop_n = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            snoop_n_q <= 1'b1;
        end else begin
            snoop_n_q <= next_snoop_n;
        end
    end

    // control pins
    assign bus.channel_attention = ca_q;
    assign bus.coprocessor_init = init_q;
    assign bus.slave_access_n = slave_n_q;

    // status pins
    assign bus.mem_io_out = mio_q;
    assign bus.data_code_out = dc_q;
    assign bus.mem_io_oe_n = mio_oe_n_q;
    assign bus.data_code_oe_n = dc_oe_n_q;
    assign bus.external_snoop_strobe_n = snoop_n_q;

    // side outputs
    assign attn_seen = attn_q;
    assign init_active = init_q;
endmodule : lcg_glue

// ==== hw/lcg_proc.sv ====
`timescale 1ns/1ps
module lcg_proc
    import lcg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    lcg_if.proc bus,
    input wire logic req_valid,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_data,
    input wire logic cop_idle,
    input wire logic grant,
    output logic req_ready,
    output logic ca_level,
    output logic init_level
);
    typedef enum {IDLE, STROBE} lcg_state_t;
    lcg_state_t state;
    lcg_state_t next_state;
    logic next_ads_n;
    logic [ADDR_W-1:0] next_addr;
    logic [DATA_W-1:0] next_data;
    logic next_ready;
    logic next_grant;
    logic ads_n_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] data_q;
    logic ready_q;
    logic grant_q;
    logic ca_q;
    logic init_q;

    always_comb begin
        next_state = state;
        next_ads_n = 1'b1;
        next_addr = addr_q;
        next_data = data_q;
        next_ready = 1'b0;
        next_grant = grant && bus.bus_request;
        unique case (state)
            IDLE: begin
                if (req_valid && cop_idle && !grant_q) begin
                    next_state = STROBE;
                    next_ads_n = 1'b0;
                    next_addr = req_addr;
                    next_data = req_data;
                end
            end
            STROBE: begin
                next_state = IDLE;
                next_ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= IDLE;
            ads_n_q <= 1'b1;
            addr_q <= '0;
            data_q <= '0;
            ready_q <= 1'b0;
            grant_q <= 1'b0;
            ca_q <= 1'b0;
            init_q <= 1'b0;
        end else begin
            state <= next_state;
            ads_n_q <= next_ads_n;
            addr_q <= next_addr;
            data_q <= next_data;
            ready_q <= next_ready;
            grant_q <= next_grant;
            ca_q <= bus.channel_attention;
            init_q <= bus.coprocessor_init;
        end
    end

    assign bus.address_strobe_n = ads_n_q;
    assign bus.mem_write = 1'b1;
    assign bus.addr = addr_q;
    assign bus.data = data_q;
    assign bus.bus_grant_in = grant_q;
    assign req_ready = ready_q;
    assign ca_level = ca_q;
    assign init_level = init_q;
endmodule : lcg_proc

// ==== test/lcg_checker.sv ====
`timescale 1ns/1ps
module lcg_checker
    import lcg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic address_strobe_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] data,
    input wire logic bus_request,
    input wire logic bus_grant_in,
    input wire logic channel_attention,
    input wire logic coprocessor_init,
    input wire logic slave_access_n,
    input wire logic mem_io_oe_n,
    input wire logic data_code_oe_n,
    input wire logic attn_seen,
    input wire logic cop_address_strobe_n,
    input wire logic cop_write,
    input wire logic external_snoop_strobe_n
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic hit;
    logic slave_hit;
    logic snoop_req;
    assign hit = !address_strobe_n && !bus_grant_in && addr == GLUE_ADDR_DEF;
    assign slave_hit = !address_strobe_n && !(bus_request && bus_grant_in)
        && addr == SLAVE_ADDR_DEF;
    assign snoop_req = bus_request && bus_grant_in && !cop_address_strobe_n
        && cop_write;
    chk_ca_toggle: assert property (hit && !data[0] |=>
        channel_attention != $past(channel_attention)) else $error("ca");
    chk_init_toggle: assert property (hit && data[0] |=>
        coprocessor_init != $past(coprocessor_init)) else $error("init");
    chk_ca_hold: assert property (!(hit && !data[0]) |=>
        $stable(channel_attention)) else $error("ca moved");
    chk_init_hold: assert property (!(hit && data[0]) |=>
        $stable(coprocessor_init)) else $error("init moved");
    chk_grant_gate: assert property (bus_grant_in |=>
        $stable({channel_attention, coprocessor_init})) else $error("gate");
    chk_slave_pulse: assert property ($fell(slave_access_n) |->
        $past(slave_hit) ##1 slave_access_n)
        else $error("slave strobe");
    chk_snoop_pulse: assert property (snoop_req |=>
        !external_snoop_strobe_n) else $error("snoop pulse");
    chk_snoop_idle: assert property (!snoop_req |=>
        external_snoop_strobe_n) else $error("snoop idle");
    chk_attn_pulse: assert property (
        attn_seen == $rose(channel_attention)) else $error("attn pulse");
    chk_owner_drive: assert property (bus_request && bus_grant_in |=>
        !mem_io_oe_n && !data_code_oe_n) else $error("owner drive");
    chk_owner_free: assert property (!(bus_request && bus_grant_in) |=>
        mem_io_oe_n && data_code_oe_n) else $error("owner free");
endmodule : lcg_checker

// ==== test/lcg_tb.sv ====
`timescale 1ns/1ps
module lcg_tb;
    import lcg_pkg::*;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
    err_total++; $display("[FAIL] %0t %h %h", $time, a, b); end end
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic grant = 1'b0;
    logic busreq = 1'b0;
    logic req_ready;
    logic cop_as_n = 1'b1;
    logic cop_wr = 1'b0;
    logic attn_seen;
    logic init_active;
    logic [ADDR_W-1:0] req_addr = '0;
    logic [DATA_W-1:0] req_data = '0;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    lcg_if bus();
    assign bus.bus_request = busreq;
    assign bus.cop_address_strobe_n = cop_as_n;
    assign bus.cop_write = cop_wr;
    lcg_glue u_lcg_glue (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
        .attn_seen(attn_seen), .init_active(init_active));
    lcg_proc u_lcg_proc (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
        .req_valid(req_valid), .req_addr(req_addr), .req_data(req_data),
        .cop_idle(1'b1), .grant(grant), .req_ready(req_ready),
        .ca_level(), .init_level());
    lcg_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
        .address_strobe_n(bus.address_strobe_n), .addr(bus.addr),
        .data(bus.data), .bus_request(bus.bus_request),
        .bus_grant_in(bus.bus_grant_in),
        .channel_attention(bus.channel_attention),
        .coprocessor_init(bus.coprocessor_init),
        .slave_access_n(bus.slave_access_n),
        .mem_io_oe_n(bus.mem_io_oe_n), .data_code_oe_n(bus.data_code_oe_n),
        .attn_seen(attn_seen), .cop_address_strobe_n(bus.cop_address_strobe_n),
        .cop_write(bus.cop_write),
        .external_snoop_strobe_n(bus.external_snoop_strobe_n));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 2000) begin
            err_total++;
            conclude();
        end
    end
    // one write cycle, held until done
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        req_addr = a;
        req_data = d;
        req_valid = 1'b1;
        repeat (20) begin
            @(negedge clk_sys);
            if (req_ready === 1'b1) break;
        end
        req_valid = 1'b0;
        @(negedge clk_sys);
    endtask : wr
    initial begin
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        `CHK({bus.channel_attention, bus.coprocessor_init}, 2'h0)
        wr(GLUE_ADDR_DEF, 32'h0);
        `CHK({bus.channel_attention, bus.coprocessor_init}, 2'h2)
        wr(GLUE_ADDR_DEF, 32'h1);
        `CHK({bus.channel_attention, bus.coprocessor_init}, 2'h3)
        `CHK(init_active, 1'h1)
        wr(GLUE_ADDR_DEF, 32'hffff_fffe);
        `CHK({bus.channel_attention, bus.coprocessor_init}, 2'h1)
        wr(GLUE_ADDR_DEF + 32'h4, 32'h1);
        `CHK({bus.channel_attention, bus.coprocessor_init}, 2'h1)
        wr(GLUE_ADDR_DEF, 32'h1);
        `CHK({bus.channel_attention, bus.coprocessor_init}, 2'h0)
        req_addr = SLAVE_ADDR_DEF;
        req_valid = 1'b1;
        @(posedge req_ready);
        @(negedge clk_sys);
        req_valid = 1'b0;
        `CHK(bus.slave_access_n, 1'h0)
        @(negedge clk_sys);
        `CHK(bus.slave_access_n, 1'h1)
        busreq = 1'b1;
        grant = 1'b1;
        repeat (3) @(negedge clk_sys);
        `CHK({bus.mem_io_oe_n, bus.mem_io_out, bus.data_code_out}, 3'h3)
        cop_as_n = 1'b0;
        cop_wr = 1'b1;
        @(negedge clk_sys);
        cop_as_n = 1'b1;
        `CHK(bus.external_snoop_strobe_n, 1'h0)
        @(negedge clk_sys);
        `CHK(bus.external_snoop_strobe_n, 1'h1)
        grant = 1'b0;
        repeat (3) @(negedge clk_sys);
        `CHK(bus.mem_io_oe_n, 1'h1)
        conclude();
    end
endmodule : lcg_tb
